// File: core/codec_homing_control.sv
// Codec homing control: detection, home commands and output substitution
`include "homing_regs.svh"
module codec_homing_control
   import homing_pkg::*;
#(
   parameter int SAMPLES = `FRAME_SAMPLES,
   parameter int WORDS = `PARAM_WORDS
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Encoder input samples, feeding only the encoder homing frame detector
   input wire logic i_enc_valid,
   input wire sample_beat_t i_enc_beat,
   // Encoder datapath signals completion of a frame
   input wire logic i_enc_frame_done,
   // Decoder input parameters
   input wire logic i_dec_valid,
   input wire param_beat_t i_dec_beat,
   // Decoder datapath signals completion of a frame
   input wire logic i_dec_frame_done,
   // Decoded speech from the datapath
   input wire logic i_speech_valid,
   input wire sample_beat_t i_speech_beat,
   // Speech out, possibly substituted
   output logic o_speech_valid,
   output sample_beat_t o_speech_beat,
   // Home commands, one-cycle pulses
   output home_cmd_t o_home,
   output logic o_enc_at_home,
   output logic o_dec_at_home
);
   logic enc_done;
   logic enc_match;
   logic dec_done;
   logic dec_full;
   logic dec_head;
   logic dec_bad;
   logic enc_pending_valid;
   logic enc_pending_home;
   logic dec_pending_valid;
   logic dec_pending_home;
   logic substitute;
   logic dec_is_home;

   enc_home_detect #(.SAMPLES(SAMPLES)) u_enc_det (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_valid(i_enc_valid),
      .i_beat(i_enc_beat),
      .o_done(enc_done),
      .o_match(enc_match)
   );

   dec_home_detect #(.WORDS(WORDS)) u_dec_det (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_valid(i_dec_valid),
      .i_beat(i_dec_beat),
      .o_done(dec_done),
      .o_full_match(dec_full),
      .o_head_match(dec_head),
      .o_bad(dec_bad)
   );

   // Shortened check allowed only from home; bad frames never home
   assign dec_is_home = ~dec_bad & (o_dec_at_home ? dec_head : dec_full);

   // Encoder verdict held until the datapath finishes that frame
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enc_pending_valid <= 1'b0;
         enc_pending_home <= 1'b0;
      end else if (enc_done) begin
         enc_pending_valid <= 1'b1;
         enc_pending_home <= enc_match;
      end else if (i_enc_frame_done) begin
         enc_pending_valid <= 1'b0;
      end
   end

   // Encoder home pulse after normal processing of the homing frame
   // The datapath zeroes offset, preboost, LAR, filter and delay memories
   // and homes voice activity and discontinuous transmission state.
   // From home the codec then yields the decoder homing frame naturally.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_home.enc_home <= 1'b0;
      end else begin
         o_home.enc_home <= i_enc_frame_done & enc_pending_valid
            & enc_pending_home;
      end
   end

   // Encoder at-home flag
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_enc_at_home <= 1'b1;
      end else if (i_enc_frame_done & enc_pending_valid) begin
         o_enc_at_home <= enc_pending_home;
      end
   end

   // Decoder verdict and substitution choice held until frame completes
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dec_pending_valid <= 1'b0;
         dec_pending_home <= 1'b0;
         substitute <= 1'b0;
      end else if (dec_done) begin
         dec_pending_valid <= 1'b1;
         dec_pending_home <= dec_is_home;
         substitute <= dec_is_home & o_dec_at_home;
      end else if (i_dec_frame_done) begin
         dec_pending_valid <= 1'b0;
         substitute <= 1'b0;
      end
   end

   // Decoder home pulse: lag to 40, memories zero, concealment and noise home
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_home.dec_home <= 1'b0;
      end else begin
         o_home.dec_home <= i_dec_frame_done & dec_pending_valid
            & dec_pending_home;
      end
   end

   // Decoder at-home flag
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dec_at_home <= 1'b1;
      end else if (i_dec_frame_done & dec_pending_valid) begin
         o_dec_at_home <= dec_pending_home;
      end
   end

   // Speech output, replaced by the encoder homing sample when substituting
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_speech_valid <= 1'b0;
         o_speech_beat <= '0;
      end else begin
         o_speech_valid <= i_speech_valid;
         o_speech_beat <= i_speech_beat;
         if (substitute) begin
            o_speech_beat.word <= `ENC_HOME_WORD;
         end
      end
   end
endmodule

// File: core/homing_regs.svh
// Constants for the codec homing control block
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH
`define FRAME_SAMPLES 160
`define SAMPLE_BITS 13
`define ENC_HOME_SAMPLE 13'h0001
`define ENC_HOME_WORD 16'h0008
`define NUM_LAR 8
`define NUM_SUBFRAMES 4
`define NUM_PULSES 13
`define HOME_LAG 7'h28
`define HOME_PULSE 3'h4
`define HOME_PULSE_ALT 3'h3
`define ALT_SUBFRAME 2'h3
`define ALT_PULSE 4'h4
`define LAR0 6'h09
`define LAR1 6'h17
`define LAR2 5'h0F
`define LAR3 5'h08
`define LAR4 4'h7
`define LAR5 4'h3
`define LAR6 3'h3
`define LAR7 3'h2
`define HOME_PREV_LAG 7'h28
`define PARAM_WORDS 76
`define SUB_WORDS 17
`define SUB_HEAD_WORDS 4
`define HEAD_WORDS 25
`endif

// File: core/homing_pkg.sv
// Types shared by the codec homing control block
package homing_pkg;
   // One speech sample word with frame markers
   typedef struct packed {
      logic [15:0] word;
      logic first;
      logic last;
   } sample_beat_t;
   // One parameter word with frame markers and bad-frame flag
   typedef struct packed {
      logic [15:0] word;
      logic first;
      logic last;
      logic bad;
   } param_beat_t;
   // Home commands to the codec datapath
   typedef struct packed {
      logic enc_home;
      logic dec_home;
   } home_cmd_t;
endpackage

// File: core/enc_home_detect.sv
// Encoder homing frame detector over a sample stream
`include "homing_regs.svh"
module enc_home_detect
   import homing_pkg::*;
#(
   parameter int SAMPLES = `FRAME_SAMPLES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire sample_beat_t i_beat,
   output logic o_done,
   output logic o_match
);
   logic [7:0] count;
   logic all_equal;
   logic aligned;
   logic next_equal;
   logic beat_ok;

   // Only the 13 valid sample bits are compared
   assign beat_ok = (i_beat.word[15:3] == `ENC_HOME_SAMPLE);
   assign next_equal = (i_beat.first ? 1'b1 : all_equal) & beat_ok;

   // Running match and alignment over one frame
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count <= 8'h00;
         all_equal <= 1'b0;
         aligned <= 1'b0;
      end else if (i_valid) begin
         all_equal <= next_equal;
         if (i_beat.first) begin
            count <= 8'h01;
            aligned <= 1'b1;
         end else begin
            count <= count + 8'h01;
         end
      end
   end

   // Verdict at every frame end; match only when the frame ends at the codec's own boundary
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_done <= 1'b0;
         o_match <= 1'b0;
      end else begin
         o_done <= i_valid & i_beat.last;
         o_match <= i_valid & i_beat.last & next_equal & (aligned | i_beat.first)
            & (count == 8'(SAMPLES - 1));
      end
   end
endmodule

// File: core/dec_home_detect.sv
// Decoder homing frame detector over a parameter stream
`include "homing_regs.svh"
module dec_home_detect
   import homing_pkg::*;
#(
   parameter int WORDS = `PARAM_WORDS
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire param_beat_t i_beat,
   output logic o_done,
   output logic o_full_match,
   output logic o_head_match,
   output logic o_bad
);
   logic [6:0] idx;
   logic [6:0] cur;
   logic full_ok;
   logic head_ok;
   logic [15:0] expect_word;
   logic [4:0] pulse;
   logic [1:0] sub;
   logic w_ok;
   logic next_full;
   logic next_head;

   assign cur = i_beat.first ? 7'h00 : idx;

   // Expected word for position: 8 LARs then 4 x (lag,gain,grid,amp,13 pulses)
   always_comb begin
      expect_word = 16'h0000;
      sub = 2'h0;
      pulse = 5'h00;
      unique case (cur)
         7'd0: expect_word = 16'(`LAR0);
         7'd1: expect_word = 16'(`LAR1);
         7'd2: expect_word = 16'(`LAR2);
         7'd3: expect_word = 16'(`LAR3);
         7'd4: expect_word = 16'(`LAR4);
         7'd5: expect_word = 16'(`LAR5);
         7'd6: expect_word = 16'(`LAR6);
         7'd7: expect_word = 16'(`LAR7);
         default: begin
            // Slot within a subframe runs 0..16, so it needs five bits
            sub = 2'((cur - 7'(`NUM_LAR)) / 7'(`SUB_WORDS));
            pulse = 5'((cur - 7'(`NUM_LAR)) % 7'(`SUB_WORDS));
            if (pulse == 5'h00) begin
               expect_word = 16'(`HOME_LAG);
            end else if (pulse < 5'(`SUB_HEAD_WORDS)) begin
               expect_word = 16'h0000;
            end else if (sub == `ALT_SUBFRAME
               && pulse == 5'(`ALT_PULSE) + 5'(`SUB_HEAD_WORDS)) begin
               expect_word = 16'(`HOME_PULSE_ALT);
            end else begin
               expect_word = 16'(`HOME_PULSE);
            end
         end
      endcase
   end

   assign w_ok = (i_beat.word == expect_word);
   assign next_full = (i_beat.first ? 1'b1 : full_ok) & w_ok;
   // Head covers LARs and the first subframe only
   assign next_head = (i_beat.first ? 1'b1 : head_ok)
      & (w_ok | (cur >= 7'(`HEAD_WORDS)));

   // Position and running matches
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         idx <= 7'h00;
         full_ok <= 1'b0;
         head_ok <= 1'b0;
      end else if (i_valid) begin
         idx <= cur + 7'h01;
         full_ok <= next_full;
         head_ok <= next_head;
      end
   end

   // Frame-end verdict
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_done <= 1'b0;
         o_full_match <= 1'b0;
         o_head_match <= 1'b0;
         o_bad <= 1'b0;
      end else begin
         o_done <= i_valid & i_beat.last;
         o_full_match <= i_valid & i_beat.last & next_full & (cur == 7'(WORDS - 1));
         o_head_match <= i_valid & i_beat.last & next_head & (cur == 7'(WORDS - 1));
         o_bad <= i_valid & i_beat.last & i_beat.bad;
      end
   end
endmodule

// File: dv/codec_homing_chk.sv
// Port checker for the codec homing control block
module codec_homing_chk
   import homing_pkg::*;
#(
   parameter int SAMPLES = 160,
   parameter int WORDS = 76
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_enc_frame_done,
   input wire logic i_dec_frame_done,
   input wire logic i_speech_valid,
   input wire sample_beat_t i_speech_beat,
   input wire logic o_speech_valid,
   input wire sample_beat_t o_speech_beat,
   input wire home_cmd_t o_home,
   input wire logic o_enc_at_home,
   input wire logic o_dec_at_home
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Home pulses come only from a frame completion
   AST_ENC_PULSE_SRC: assert property (o_home.enc_home |-> $past(i_enc_frame_done))
      else $error("encoder home pulse without frame done");
   AST_DEC_PULSE_SRC: assert property (o_home.dec_home |-> $past(i_dec_frame_done))
      else $error("decoder home pulse without frame done");
   AST_ENC_PULSE_ONE: assert property (o_home.enc_home |=> !o_home.enc_home)
      else $error("encoder home pulse too long");
   AST_DEC_PULSE_ONE: assert property (o_home.dec_home |=> !o_home.dec_home)
      else $error("decoder home pulse too long");
   // Flags are set with the home pulses and hold between frame completions
   AST_ENC_FLAG_SET: assert property (o_home.enc_home |-> o_enc_at_home)
      else $error("encoder flag not set on homing");
   AST_DEC_FLAG_SET: assert property (o_home.dec_home |-> o_dec_at_home)
      else $error("decoder flag not set on homing");
   AST_ENC_FLAG_HOLD: assert property (!$past(i_enc_frame_done) |-> $stable(o_enc_at_home))
      else $error("encoder flag moved without frame done");
   AST_DEC_FLAG_HOLD: assert property (!$past(i_dec_frame_done) |-> $stable(o_dec_at_home))
      else $error("decoder flag moved without frame done");
   // Speech is passed one cycle later, unchanged unless substituted
   AST_SPEECH_DELAY: assert property (i_speech_valid |=> o_speech_valid)
      else $error("speech beat lost");
   AST_SPEECH_COPY: assert property (o_speech_valid && o_speech_beat.word != 16'h0008
      |-> o_speech_beat.word == $past(i_speech_beat.word))
      else $error("speech word altered");
   // Main scenarios
   COV_ENC_HOME: cover property (o_home.enc_home);
   COV_DEC_HOME: cover property (o_home.dec_home);
   COV_SUBST: cover property (o_speech_valid && $past(i_speech_beat.word) != 16'h0008
      && o_speech_beat.word == 16'h0008);
endmodule
bind codec_homing_control codec_homing_chk #(.SAMPLES(SAMPLES), .WORDS(WORDS)) u_chk (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_enc_frame_done(i_enc_frame_done),
   .i_dec_frame_done(i_dec_frame_done), .i_speech_valid(i_speech_valid),
   .i_speech_beat(i_speech_beat), .o_speech_valid(o_speech_valid),
   .o_speech_beat(o_speech_beat), .o_home(o_home), .o_enc_at_home(o_enc_at_home),
   .o_dec_at_home(o_dec_at_home));

// File: dv/homing_frame_source.sv
// Sample and parameter frame source model
module homing_frame_source
   import homing_pkg::*;
(
   input wire logic i_clk,
   output logic o_enc_valid,
   output sample_beat_t o_enc_beat,
   output logic o_dec_valid,
   output param_beat_t o_dec_beat
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] lar_tab [8] = '{16'h0009, 16'h0017, 16'h000F, 16'h0008,
      16'h0007, 16'h0003, 16'h0003, 16'h0002};
   // Idle lines
   initial begin
      o_enc_valid = 1'h0;
      o_enc_beat = '0;
      o_dec_valid = 1'h0;
      o_dec_beat = '0;
   end
   // Homing parameter word at position i
   function automatic logic [15:0] home_param(input int i);
      int j;
      j = (i - 8) % 17;
      if (i < 8) return lar_tab[i];
      if (j == 0) return 16'h0028;
      if (j < 4) return 16'h0000;
      return (i == 67) ? 16'h0003 : 16'h0004;
   endfunction
   // Speech frame of n beats, one odd sample at index odd
   task automatic send_enc(input int n, input int odd);
      for (int i = 0; i < n; i++) begin
         @(negedge i_clk);
         o_enc_valid = 1'h1;
         o_enc_beat.word = (i == odd) ? 16'h0010 : 16'h0008;
         o_enc_beat.first = (i == 0);
         o_enc_beat.last = (i == n - 1);
      end
      @(negedge i_clk);
      o_enc_valid = 1'h0;
      o_enc_beat.word = ~o_enc_beat.word; // No stale data left standing
   endtask
   // Parameter frame, word flip toggled in bit 0
   task automatic send_dec(input int flip, input bit bad);
      for (int i = 0; i < 76; i++) begin
         @(negedge i_clk);
         o_dec_valid = 1'h1;
         o_dec_beat.word = home_param(i) ^ {15'h0, i == flip};
         o_dec_beat.first = (i == 0);
         o_dec_beat.last = (i == 75);
         o_dec_beat.bad = bad;
      end
      @(negedge i_clk);
      o_dec_valid = 1'h0;
      o_dec_beat.word = ~o_dec_beat.word;
   endtask
endmodule

// File: dv/codec_homing_control_test.sv
// Self-checking bench for the codec homing control block
module codec_homing_control_test
   import homing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic enc_valid, dec_valid, enc_done, dec_done, speech_valid, out_valid;
   logic enc_at_home, dec_at_home;
   sample_beat_t enc_beat, speech_beat, out_beat;
   param_beat_t dec_beat;
   home_cmd_t home;
   int mismatches = 0;
   int tests_run = 0;
   always #2 clk = ~clk;
   homing_frame_source u_src (.i_clk(clk), .o_enc_valid(enc_valid), .o_enc_beat(enc_beat),
      .o_dec_valid(dec_valid), .o_dec_beat(dec_beat));
   codec_homing_control u_codec_homing_control (.i_clk(clk), .i_rst_b(rst_b),
      .i_enc_valid(enc_valid), .i_enc_beat(enc_beat), .i_enc_frame_done(enc_done),
      .i_dec_valid(dec_valid), .i_dec_beat(dec_beat), .i_dec_frame_done(dec_done),
      .i_speech_valid(speech_valid), .i_speech_beat(speech_beat),
      .o_speech_valid(out_valid), .o_speech_beat(out_beat), .o_home(home),
      .o_enc_at_home(enc_at_home), .o_dec_at_home(dec_at_home));
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Speech beat for decoder frames only, then frame done and home checks
   task automatic close(input bit enc, input bit pulse, input bit flag, input logic [15:0] w);
      repeat (2) @(negedge clk);
      if (!enc) begin
         speech_valid = 1'h1;
         speech_beat = {16'h1230, 1'h1, 1'h1};
         @(negedge clk);
         speech_valid = 1'h0;
         speech_beat.word = 16'hEDCF;
         chk(out_valid, 1'h1);
         chk(out_beat.word, w);
         chk({out_beat.first, out_beat.last}, 2'h3);
      end
      enc_done = enc;
      dec_done = !enc;
      @(negedge clk);
      enc_done = 1'h0;
      dec_done = 1'h0;
      chk(enc ? home.enc_home : home.dec_home, pulse);
      chk(enc ? enc_at_home : dec_at_home, flag);
      @(negedge clk);
   endtask
   task automatic t_reset;
      chk(home, 2'h0);
      chk({enc_at_home, dec_at_home}, 2'h3);
      $display("reset test done");
   endtask
   task automatic t_enc;
      u_src.send_enc(160, -1);
      close(1, 1, 1, 0);
      u_src.send_enc(160, 7);
      close(1, 0, 0, 0);
      u_src.send_enc(159, -1);
      close(1, 0, 0, 0);
      u_src.send_enc(160, -1);
      close(1, 1, 1, 0);
      $display("encoder test done");
   endtask
   task automatic t_dec;
      u_src.send_dec(0, 0);
      close(0, 0, 0, 16'h1230);
      u_src.send_dec(-1, 1);
      close(0, 0, 0, 16'h1230);
      u_src.send_dec(-1, 0);
      close(0, 1, 1, 16'h1230);
      u_src.send_dec(-1, 0);
      close(0, 1, 1, 16'h0008);
      u_src.send_dec(67, 0);
      close(0, 1, 1, 16'h0008);
      u_src.send_dec(20, 0);
      close(0, 0, 0, 16'h1230);
      $display("decoder test done");
   endtask
   // Main sequence
   initial begin
      enc_done = 1'h0;
      dec_done = 1'h0;
      speech_valid = 1'h0;
      speech_beat = '0;
      repeat (6) @(negedge clk);
      rst_b = 1'h1;
      t_reset();
      t_enc();
      t_dec();
      conclude();
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("[ERR] t=%0t watchdog got %h exp %h", $time, 1'h1, 1'h0);
      conclude();
   end
endmodule
